// file: logic/thermal_clip_pkg.sv
// package: register map, field layout and input carriers for the thermal/clip status bank
package thermal_clip_pkg;
   localparam logic [7:0] THERMAL_WARN_OFFSET = 8'h17;
   localparam logic [7:0] CLIP_MEM_OFFSET = 8'h18;
   localparam logic [7:0] CLIP_LIVE_OFFSET = 8'h19;
   localparam logic [7:0] THERMAL_WARN_RESET = 8'h00;
   localparam logic [7:0] CLIP_MEM_RESET = 8'h00;
   localparam logic [7:0] CLIP_LIVE_RESET = 8'h00;
   localparam logic [7:0] UNMAPPED_READ = 8'h00;
   localparam int FOLDBACK_BIT = 5;
   localparam int DIE_WARN_BIT = 4;
   localparam int CHAN_MSB = 3;
   localparam int CHAN_COUNT = 4;

   // index 3 is channel 1, index 0 is channel 4, as in the register
   typedef struct packed {
      logic foldback_active_flag;
      logic die_heat_warning;
      logic [CHAN_COUNT-1:0] chan_heat_warning;
      logic [CHAN_COUNT-1:0] chan_clip_live;
   } detector_s;

   typedef struct packed {
      logic rd_en;
      logic wr_en;
      logic [7:0] addr;
   } reg_access_s;
endpackage : thermal_clip_pkg

// file: logic/thermal_clip_warning_status_bank.sv
// thermal warning and clip detect status register bank
//
// What this block does
// - bit 5 follows gain foldback engaged
// - bit 4 follows die over-temperature warning
// - bits 3..0 live channel heat warnings
// - thermal status at 0x17, resets zero
// - clip event latches channel memory bit
// - reading clip memory clears it
// - clip memory at 0x18, upper bits zero
// - clip live bits at 0x19 follow detectors
`timescale 1ns/10ps
`default_nettype none
module thermal_clip_warning_status_bank
   import thermal_clip_pkg::*;
(
   input wire logic clk_in,
   input wire logic rst_in,
   input wire detector_s det_in,
   input wire reg_access_s acc_in,
   input wire logic [7:0] wr_data_in,
   output logic [7:0] rd_data_out,
   output logic rd_valid_out
);

   // ***********************************
   // live status capture
   // ***********************************
   logic [7:0] thermal_r;
   logic [7:0] thermal_nxt;
   logic [7:0] clip_live_r;
   logic [7:0] clip_live_nxt;

   // registered so one read sees a single coherent detector snapshot
   always_comb begin
      thermal_nxt = THERMAL_WARN_RESET;
      thermal_nxt[FOLDBACK_BIT] = det_in.foldback_active_flag;
      thermal_nxt[DIE_WARN_BIT] = det_in.die_heat_warning;
      thermal_nxt[CHAN_MSB:0] = det_in.chan_heat_warning;
      clip_live_nxt = CLIP_LIVE_RESET;
      clip_live_nxt[CHAN_MSB:0] = det_in.chan_clip_live;
   end

   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         thermal_r <= THERMAL_WARN_RESET;
         clip_live_r <= CLIP_LIVE_RESET;
      end else begin
         thermal_r <= thermal_nxt;
         clip_live_r <= clip_live_nxt;
      end
   end

   // ***********************************
   // clip event memory
   // ***********************************
   logic [7:0] clip_mem_r;
   logic [7:0] clip_mem_nxt;
   logic mem_read;

   // one address compare shared by the clear strobe and the read mux
   function automatic logic addr_is(input logic [7:0] a, input logic [7:0] off);
      return a == off;
   endfunction : addr_is

   // writes never decoded
   // wr_data_in has no path to state, so a stray write cannot drop events
   assign mem_read = acc_in.rd_en && addr_is(acc_in.addr, CLIP_MEM_OFFSET);

   always_comb begin
      clip_mem_nxt = clip_mem_r;
      if (mem_read) begin
         clip_mem_nxt = CLIP_MEM_RESET;
      end
      clip_mem_nxt[CHAN_MSB:0] = clip_mem_nxt[CHAN_MSB:0] | det_in.chan_clip_live;
   end

   // bits 7..4 have no set path, hence they cannot leak ones
   // reset value, upper bits held zero
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         clip_mem_r <= CLIP_MEM_RESET;
      end else begin
         clip_mem_r <= clip_mem_nxt;
      end
   end

   // ***********************************
   // read port
   // ***********************************
   // rd_data_out holds between reads; only rd_valid_out marks a fresh answer
   logic [7:0] rd_data_nxt;
   logic rd_valid_nxt;

   function automatic logic [7:0] read_mux(input logic [7:0] a, input logic [7:0] t,
                                           input logic [7:0] m, input logic [7:0] l);
      logic [7:0] v;
      v = UNMAPPED_READ;
      if (addr_is(a, THERMAL_WARN_OFFSET)) v = t;
      else if (addr_is(a, CLIP_MEM_OFFSET)) v = m;
      else if (addr_is(a, CLIP_LIVE_OFFSET)) v = l;
      return v;
   endfunction : read_mux

   always_comb begin
      rd_valid_nxt = acc_in.rd_en;
      rd_data_nxt = rd_data_out;
      // memory read returns the pre-clear value
      if (acc_in.rd_en) begin
         rd_data_nxt = read_mux(acc_in.addr, thermal_r, clip_mem_r, clip_live_r);
      end
   end

   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         rd_data_out <= 8'h00;
         rd_valid_out <= 1'b0;
      end else begin
         rd_data_out <= rd_data_nxt;
         rd_valid_out <= rd_valid_nxt;
      end
   end

   // ***********************************
   // assertions: live status
   // ***********************************
   // sampled !rst_in keeps the release edge, where the flops still reset, out
   a_foldback_bit: assert property (@(posedge clk_in) disable iff (rst_in)
      !rst_in |=> thermal_r[FOLDBACK_BIT] == $past(det_in.foldback_active_flag))
      else $error("foldback bit mismatch");
   a_die_warn_bit: assert property (@(posedge clk_in) disable iff (rst_in)
      !rst_in |=> thermal_r[DIE_WARN_BIT] == $past(det_in.die_heat_warning))
      else $error("die warning bit mismatch");
   a_chan_warn_bits: assert property (@(posedge clk_in) disable iff (rst_in)
      !rst_in |=> thermal_r[CHAN_MSB:0] == $past(det_in.chan_heat_warning))
      else $error("channel warning bits mismatch");
   // channel 1 sits at the top of the nibble, channel 4 at the bottom
   a_chan1_warn_bit: assert property (@(posedge clk_in) disable iff (rst_in)
      !rst_in |=> thermal_r[3] == $past(det_in.chan_heat_warning[3]))
      else $error("channel 1 warning bit mismatch");
   a_chan4_warn_bit: assert property (@(posedge clk_in) disable iff (rst_in)
      !rst_in |=> thermal_r[0] == $past(det_in.chan_heat_warning[0]))
      else $error("channel 4 warning bit mismatch");
   // reset must win over whatever the detectors show
   a_thermal_reset: assert property (@(posedge clk_in)
      rst_in |=> thermal_r == THERMAL_WARN_RESET && clip_live_r == CLIP_LIVE_RESET)
      else $error("status registers not zero after reset");
   a_thermal_reserved: assert property (@(posedge clk_in) disable iff (rst_in)
      thermal_r[7:6] == 2'b00)
      else $error("thermal reserved bits set");
   a_clip_live_bits: assert property (@(posedge clk_in) disable iff (rst_in)
      !rst_in |=> clip_live_r == {4'h0, $past(det_in.chan_clip_live)})
      else $error("live clip bits mismatch");
   a_live_reserved: assert property (@(posedge clk_in) disable iff (rst_in)
      clip_live_r[7:4] == 4'h0)
      else $error("live clip reserved bits set");

   // ***********************************
   // assertions: clip memory
   // ***********************************
   a_clip_mem_reset: assert property (@(posedge clk_in)
      rst_in |=> clip_mem_r == CLIP_MEM_RESET)
      else $error("clip memory not zero after reset");
   a_clip_latch: assert property (@(posedge clk_in) disable iff (rst_in)
      !rst_in && det_in.chan_clip_live != 4'h0 |=>
         (clip_mem_r[CHAN_MSB:0] & $past(det_in.chan_clip_live)) == $past(det_in.chan_clip_live))
      else $error("clip event not latched");
   // a latched bit may only drop on a clearing read
   a_clip_hold: assert property (@(posedge clk_in) disable iff (rst_in)
      !rst_in && !mem_read |=> (clip_mem_r & $past(clip_mem_r)) == $past(clip_mem_r))
      else $error("latched clip bit dropped without a read");
   a_clip_clear: assert property (@(posedge clk_in) disable iff (rst_in)
      !rst_in && mem_read && det_in.chan_clip_live == 4'h0 |=> clip_mem_r == CLIP_MEM_RESET
         ##0 rd_valid_out && rd_data_out == $past(clip_mem_r))
      else $error("clip memory not cleared by read");
   a_clip_reserved: assert property (@(posedge clk_in) disable iff (rst_in)
      clip_mem_r[7:4] == 4'h0)
      else $error("clip memory reserved bits set");
   // the read cycle's live clip must survive the clear
   a_set_beats_clear: assert property (@(posedge clk_in) disable iff (rst_in)
      !rst_in && mem_read |=> clip_mem_r == {4'h0, $past(det_in.chan_clip_live)})
      else $error("clip event lost on clearing read");

   // ***********************************
   // assertions: read port
   // ***********************************
   a_thermal_readback: assert property (@(posedge clk_in) disable iff (rst_in)
      !rst_in && acc_in.rd_en && acc_in.addr == THERMAL_WARN_OFFSET |=>
         rd_valid_out && rd_data_out == $past(thermal_r))
      else $error("thermal status read back wrong");
   a_mem_readback: assert property (@(posedge clk_in) disable iff (rst_in)
      !rst_in && mem_read |=>
         rd_valid_out && rd_data_out == $past(clip_mem_r) && rd_data_out[7:4] == 4'h0)
      else $error("clip memory read back wrong");
   a_live_readback: assert property (@(posedge clk_in) disable iff (rst_in)
      !rst_in && acc_in.rd_en && acc_in.addr == CLIP_LIVE_OFFSET |=>
         rd_valid_out && rd_data_out == $past(clip_live_r))
      else $error("live clip status read back wrong");
   a_write_ignored: assert property (@(posedge clk_in) disable iff (rst_in)
      acc_in.wr_en && !acc_in.rd_en && det_in.chan_clip_live == 4'h0 |=> $stable(clip_mem_r))
      else $error("write changed clip memory");
   a_write_no_valid: assert property (@(posedge clk_in) disable iff (rst_in)
      !rst_in && acc_in.wr_en && !acc_in.rd_en |=> !rd_valid_out && $stable(rd_data_out))
      else $error("write produced a read answer");

   // ***********************************
   // coverage of main scenarios
   // ***********************************
   c_clip_read: cover property (@(posedge clk_in) disable iff (rst_in) mem_read && clip_mem_r != 8'h00);
   c_set_on_clear: cover property (@(posedge clk_in) disable iff (rst_in) mem_read && det_in.chan_clip_live != 4'h0);
   c_foldback: cover property (@(posedge clk_in) disable iff (rst_in) thermal_r[FOLDBACK_BIT]);
   c_unmapped: cover property (@(posedge clk_in) disable iff (rst_in) acc_in.rd_en && acc_in.addr > CLIP_LIVE_OFFSET);
   c_write_access: cover property (@(posedge clk_in) disable iff (rst_in) acc_in.wr_en && !acc_in.rd_en);

endmodule : thermal_clip_warning_status_bank
`default_nettype wire

// file: tb/host_reader.sv
// host controller model: one register access per request
`timescale 1ns/10ps
`default_nettype none
module host_reader
   import thermal_clip_pkg::*;
(
   input wire logic clk_in,
   input wire logic go_in,
   input wire logic wr_in,
   input wire logic [7:0] addr_in,
   input wire logic [7:0] rd_data_in,
   input wire logic rd_valid_in,
   output var reg_access_s acc_out,
   output logic [7:0] data_out,
   output logic done_out
);
   // idle address is inverted every cycle, so the stale value comes back on every second idle cycle
   always_ff @(posedge clk_in) begin
      acc_out.rd_en <= go_in & ~wr_in;
      acc_out.wr_en <= go_in & wr_in;
      acc_out.addr <= go_in ? addr_in : ~acc_out.addr;
      done_out <= rd_valid_in;
      if (rd_valid_in) begin
         data_out <= rd_data_in;
      end
   end
endmodule : host_reader
`default_nettype wire

// file: tb/thermal_clip_warning_status_bank_tb.sv
// self-checking bench for the thermal and clip status bank
`timescale 1ns/10ps
`default_nettype none
`define CHECK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin errors++; $display("ERROR %s exp %h got %h", nm, e, g); end end
module thermal_clip_warning_status_bank_tb;
   import thermal_clip_pkg::*;
   logic clk_in = 0, rst_in = 1, go = 0, wr = 0, rd_valid, host_done;
   logic [7:0] addr = 8'h00, wr_data = 8'h00, rd_data, host_data, mem_m;
   detector_s det = '0;
   reg_access_s acc;
   logic [31:0] lfsr = 32'h9b02_9941;
   int errors = 0, tests_run = 0;
   host_reader i_host (.clk_in(clk_in), .go_in(go), .wr_in(wr), .addr_in(addr), .rd_data_in(rd_data),
      .rd_valid_in(rd_valid), .acc_out(acc), .data_out(host_data), .done_out(host_done));
   thermal_clip_warning_status_bank i_dut (.clk_in(clk_in), .rst_in(rst_in), .det_in(det), .acc_in(acc),
      .wr_data_in(wr_data), .rd_data_out(rd_data), .rd_valid_out(rd_valid));
   initial forever #4 clk_in = ~clk_in;
   // clip memory model: set wins over the clearing read
   always @(posedge clk_in) mem_m <= rst_in ? 8'h00 : ((acc.rd_en && acc.addr == CLIP_MEM_OFFSET) ? 8'h00 : mem_m)
      | {4'h0, det.chan_clip_live};
   function automatic logic [31:0] next_rand(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : next_rand
   function automatic logic [7:0] expect_read(input logic [7:0] a, input detector_s d, input logic [7:0] m);
      case (a)
         THERMAL_WARN_OFFSET: return {2'b00, d.foldback_active_flag, d.die_heat_warning, d.chan_heat_warning};
         CLIP_MEM_OFFSET: return m;
         CLIP_LIVE_OFFSET: return {4'h0, d.chan_clip_live};
         default: return UNMAPPED_READ;
      endcase
   endfunction : expect_read
   task automatic final_report;
      $display("comparisons %0d mismatches %0d", tests_run, errors);
      if (errors == 0 && tests_run > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask : final_report
   task automatic host_access(input logic [7:0] a, input logic w);
      logic [7:0] exp_v;
      int n;
      @(posedge clk_in);
      go <= 1'b1;
      wr <= w;
      addr <= a;
      wr_data <= lfsr[7:0];
      @(posedge clk_in);
      go <= 1'b0;
      #1;
      exp_v = expect_read(a, det, mem_m);
      n = 0;
      if (!w) begin
         do begin
            @(posedge clk_in);
            #1;
            n++;
         end while (host_done !== 1'b1 && n < 20);
         if (host_done !== 1'b1) begin
            errors++;
            final_report();
         end else begin
            `CHECK("rd_data", exp_v, host_data)
         end
      end
   endtask : host_access
   initial begin
      repeat (10) @(posedge clk_in);
      rst_in <= 1'b0;
      host_access(THERMAL_WARN_OFFSET, 1'b0);
      host_access(CLIP_MEM_OFFSET, 1'b0);
      // corner: events, then a quiet clearing read must leave memory empty
      @(posedge clk_in);
      det.chan_clip_live <= 4'ha;
      @(posedge clk_in);
      det.chan_clip_live <= 4'h0;
      host_access(CLIP_MEM_OFFSET, 1'b0);
      `CHECK("mem_latched", 8'h0a, host_data)
      host_access(CLIP_MEM_OFFSET, 1'b0);
      `CHECK("mem_cleared", 8'h00, host_data)
      // corner: clip held through a clearing read stays latched
      @(posedge clk_in);
      det.chan_clip_live <= 4'h5;
      host_access(CLIP_MEM_OFFSET, 1'b0);
      @(posedge clk_in);
      det.chan_clip_live <= 4'h0;
      host_access(CLIP_MEM_OFFSET, 1'b0);
      `CHECK("mem_kept", 8'h05, host_data)
      $display("corner tests done");
      for (int i = 0; i < 30; i++) begin
         // short clip bursts must all accumulate
         repeat (3) begin
            @(posedge clk_in);
            lfsr = next_rand(lfsr);
            det.chan_clip_live <= lfsr[3:0];
         end
         @(posedge clk_in);
         det <= lfsr[13:4];
         host_access(CLIP_MEM_OFFSET, 1'b0);
         host_access(THERMAL_WARN_OFFSET, 1'b0);
         host_access(CLIP_LIVE_OFFSET, 1'b0);
         host_access(CLIP_MEM_OFFSET, 1'b0);
         host_access(CLIP_MEM_OFFSET + lfsr[16], 1'b1);
         host_access(CLIP_MEM_OFFSET, 1'b0);
         host_access(lfsr[23:16] | 8'h20, 1'b0);
         $display("test %0d done", i);
      end
      // mid-run reset after every flag was raised: read data, clip memory and thermal status must read zero again
      @(posedge clk_in);
      det <= '1;
      host_access(THERMAL_WARN_OFFSET, 1'b0);
      `CHECK("thermal_all", 8'h3f, host_data)
      @(posedge clk_in);
      det <= '0;
      rst_in <= 1'b1;
      repeat (3) @(posedge clk_in);
      rst_in <= 1'b0;
      @(posedge clk_in);
      #1;
      `CHECK("rd_data_rst", 8'h00, rd_data)
      host_access(CLIP_MEM_OFFSET, 1'b0);
      `CHECK("mem_rst", CLIP_MEM_RESET, host_data)
      host_access(THERMAL_WARN_OFFSET, 1'b0);
      `CHECK("thermal_rst", THERMAL_WARN_RESET, host_data)
      $display("reset test done");
      final_report();
   end
endmodule : thermal_clip_warning_status_bank_tb
`default_nettype wire
